/* src/timer_three_pkg.sv */
// shared constants and carrier types for the third timer/counter
package timer_three_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int FLAG_W = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_HIGH = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h7;

  // control register fields
  localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
  localparam int BIT_RUN = 2;
  localparam int BIT_EXTERNAL_ENABLE = 3;
  localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
  localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
  localparam logic [DATA_W-1:0] CONTROL_WMASK = 8'h3d;
  // mode register fields
  localparam int BIT_DOWN_COUNT_ENABLE = 0;
  localparam logic [DATA_W-1:0] MODE_WMASK = 8'h01;
  // status and mask fields
  localparam int BIT_OVERFLOW_FLAG = 0;
  localparam int BIT_EXTERNAL_FLAG = 1;
  localparam int BIT_PIN_LEVEL = 2;

  // reset values
  localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;
  localparam logic [FLAG_W-1:0] STATUS_RST = 2'h0;
  localparam logic [FLAG_W-1:0] MASK_RST = 2'h0;
  localparam logic PIN_RST = 1'b1;
  localparam logic [CNT_W-1:0] COUNT_TOP = 16'hffff;
  localparam logic [CNT_W-1:0] COUNT_STEP = 16'h0001;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b00,
    MODE_UPDOWN = 2'b01,
    MODE_BAUD = 2'b10
  } mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] control;
    logic [DATA_W-1:0] mode;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reload;
    logic [DATA_W-1:0] rd_data;
    logic irq;
    logic tick;
    logic pin_prev;
  } timer_state_s;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
  } sync_state_s;

  typedef struct packed {
    logic [FLAG_W-1:0] status;
    logic [FLAG_W-1:0] mask;
  } flags_state_s;

endpackage

/* src/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic level_r
);
  timer_three_pkg::sync_state_s st_r;
  timer_three_pkg::sync_state_s st_nxt;

  // ff1 feeds ff2 only, so no logic sees a metastable value
  always_comb begin
    st_nxt = st_r;
    st_nxt.ff1 = pin;
    st_nxt.ff2 = st_r.ff1;
    st_nxt.ff3 = st_r.ff2;
    if (st_r.ff2 == st_r.ff3) begin
      st_nxt.lvl = st_r.ff3;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '{timer_three_pkg::PIN_RST, timer_three_pkg::PIN_RST,
                timer_three_pkg::PIN_RST, timer_three_pkg::PIN_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_r = st_r.lvl;
endmodule

/* src/sticky_flags.sv */
// sticky event flags with write-one-to-clear and interrupt mask
`timescale 1ns/100ps
module sticky_flags (
  input wire logic clock,
  input wire logic rst,
  input wire logic [timer_three_pkg::FLAG_W-1:0] set,
  input wire logic [timer_three_pkg::FLAG_W-1:0] toggle,
  input wire logic [timer_three_pkg::FLAG_W-1:0] clr,
  input wire logic mask_we,
  input wire logic [timer_three_pkg::FLAG_W-1:0] mask_wdata,
  input wire logic [timer_three_pkg::FLAG_W-1:0] block,
  output logic [timer_three_pkg::FLAG_W-1:0] status,
  output logic [timer_three_pkg::FLAG_W-1:0] mask,
  output logic irq_level
);
  timer_three_pkg::flags_state_s st_r;
  timer_three_pkg::flags_state_s st_nxt;

  // hardware set or toggle beats a software clear in the same cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.status = ((st_r.status & ~clr) & ~toggle)
                    | (~st_r.status & toggle) | set;
    if (mask_we) begin
      st_nxt.mask = mask_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '{timer_three_pkg::STATUS_RST, timer_three_pkg::MASK_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign mask = st_r.mask;
  assign irq_level = |(st_r.status & st_r.mask & ~block);
endmodule

/* src/updown_reload_baud_timer.sv */
// third timer/counter: up/down auto-reload and baud generator modes
// Notes on behaviour
// - Clearing capture_reload_select with down_count_enable set selects up/down auto-reload.
// - In up/down auto-reload the 16-bit count rises while the pin is high and falls while low.
// - Counting up, an overflow loads the count from the reload/capture bytes.
// - Counting down, a count equal to the reload/capture pair loads all ones.
// - Every reload in up/down mode sets the overflow flag, whatever the direction.
// - Every up/down reload inverts the external flag, which then raises no interrupt.
// - Setting either clock select bit selects baud rate generator operation.
// - The baud generator counts in 16 bits and reloads on rollover from all ones.
// - Baud generator rollover leaves the overflow flag alone.
// - With external_enable set, a falling pin edge in baud mode sets the external flag and interrupts.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
module updown_reload_baud_timer (
  input wire logic clock,
  input wire logic rst,
  input wire timer_three_pkg::bus_req_s bus_req,
  input wire logic external_trigger_pin,
  output logic [timer_three_pkg::DATA_W-1:0] rd_data_r,
  output logic irq_r,
  output logic baud_tick_r
);
  timer_three_pkg::timer_state_s st_r;
  timer_three_pkg::timer_state_s st_nxt;
  timer_three_pkg::mode_e mode;
  logic pin_lvl;
  logic pin_fall;
  logic at_top;
  logic at_reload;
  logic running;
  logic cnt_wr;
  logic [timer_three_pkg::FLAG_W-1:0] flag_set;
  logic [timer_three_pkg::FLAG_W-1:0] flag_tgl;
  logic [timer_three_pkg::FLAG_W-1:0] flag_clr;
  logic [timer_three_pkg::FLAG_W-1:0] flag_block;
  logic [timer_three_pkg::FLAG_W-1:0] status;
  logic [timer_three_pkg::FLAG_W-1:0] mask;
  logic mask_we;
  logic irq_level;
  logic reload_ev;

  // baud selection outranks the up/down choice
  function automatic timer_three_pkg::mode_e mode_of(
    input logic [timer_three_pkg::DATA_W-1:0] control,
    input logic [timer_three_pkg::DATA_W-1:0] mode_reg
  );
    logic baud;
    logic updown;
    baud = control[timer_three_pkg::BIT_RECEIVE_CLOCK_SELECT]
           | control[timer_three_pkg::BIT_TRANSMIT_CLOCK_SELECT];
    updown = !control[timer_three_pkg::BIT_CAPTURE_RELOAD_SELECT]
             && mode_reg[timer_three_pkg::BIT_DOWN_COUNT_ENABLE];
    if (baud) begin
      return timer_three_pkg::MODE_BAUD;
    end else if (updown) begin
      return timer_three_pkg::MODE_UPDOWN;
    end
    return timer_three_pkg::MODE_FREE;
  endfunction

  pin_sync pin_sync_i (
    .clock(clock),
    .rst(rst),
    .pin(external_trigger_pin),
    .level_r(pin_lvl)
  );

  sticky_flags sticky_flags_i (
    .clock(clock),
    .rst(rst),
    .set(flag_set),
    .toggle(flag_tgl),
    .clr(flag_clr),
    .mask_we(mask_we),
    .mask_wdata(bus_req.wdata[timer_three_pkg::FLAG_W-1:0]),
    .block(flag_block),
    .status(status),
    .mask(mask),
    .irq_level(irq_level)
  );

  assign mode = mode_of(st_r.control, st_r.mode);
  assign running = st_r.control[timer_three_pkg::BIT_RUN];
  assign at_top = st_r.count == timer_three_pkg::COUNT_TOP;
  assign at_reload = st_r.count == st_r.reload;
  assign pin_fall = st_r.pin_prev && !pin_lvl;
  assign cnt_wr = bus_req.wr
                  && (bus_req.addr == timer_three_pkg::OFS_COUNT_LOW
                  || bus_req.addr == timer_three_pkg::OFS_COUNT_HIGH);
  assign mask_we = bus_req.wr && bus_req.addr == timer_three_pkg::OFS_MASK;

  // external flag may still be read, but in up/down mode it never interrupts
  always_comb begin
    flag_block = '0;
    if (mode == timer_three_pkg::MODE_UPDOWN) begin
      flag_block[timer_three_pkg::BIT_EXTERNAL_FLAG] = 1'b1;
    end
  end

  always_comb begin
    flag_clr = '0;
    if (bus_req.wr && bus_req.addr == timer_three_pkg::OFS_STATUS) begin
      flag_clr = bus_req.wdata[timer_three_pkg::FLAG_W-1:0];
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_data = 8'h00;
    st_nxt.tick = 1'b0;
    st_nxt.pin_prev = pin_lvl;
    st_nxt.irq = irq_level;
    flag_set = '0;
    flag_tgl = '0;
    reload_ev = 1'b0;
    if (running) begin
      case (mode)
        timer_three_pkg::MODE_UPDOWN: begin
          if (pin_lvl) begin
            if (at_top) begin
              st_nxt.count = st_r.reload;
              reload_ev = 1'b1;
            end else begin
              st_nxt.count = st_r.count + timer_three_pkg::COUNT_STEP;
            end
          end else begin
            if (at_reload) begin
              st_nxt.count = timer_three_pkg::COUNT_TOP;
              reload_ev = 1'b1;
            end else begin
              st_nxt.count = st_r.count - timer_three_pkg::COUNT_STEP;
            end
          end
          if (reload_ev) begin
            flag_set[timer_three_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
            flag_tgl[timer_three_pkg::BIT_EXTERNAL_FLAG] = 1'b1;
          end
        end
        timer_three_pkg::MODE_BAUD: begin
          // rollover drives the tick only; overflow flag stays untouched
          if (at_top) begin
            st_nxt.count = st_r.reload;
            st_nxt.tick = 1'b1;
          end else begin
            st_nxt.count = st_r.count + timer_three_pkg::COUNT_STEP;
          end
        end
        timer_three_pkg::MODE_FREE: begin
          if (at_top) begin
            st_nxt.count = st_r.reload;
            flag_set[timer_three_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
          end else begin
            st_nxt.count = st_r.count + timer_three_pkg::COUNT_STEP;
          end
        end
        default: begin
          st_nxt.count = st_r.count;
        end
      endcase
    end
    // edge is watched even while stopped, only in baud mode
    if (mode == timer_three_pkg::MODE_BAUD && pin_fall
        && st_r.control[timer_three_pkg::BIT_EXTERNAL_ENABLE]) begin
      flag_set[timer_three_pkg::BIT_EXTERNAL_FLAG] = 1'b1;
    end
    // a software write to a count byte wins over counting for that byte in that cycle
    if (bus_req.wr) begin
      case (bus_req.addr)
        timer_three_pkg::OFS_CONTROL: begin
          st_nxt.control = bus_req.wdata & timer_three_pkg::CONTROL_WMASK;
        end
        timer_three_pkg::OFS_MODE: begin
          st_nxt.mode = bus_req.wdata & timer_three_pkg::MODE_WMASK;
        end
        timer_three_pkg::OFS_COUNT_LOW: begin
          st_nxt.count[7:0] = bus_req.wdata;
        end
        timer_three_pkg::OFS_COUNT_HIGH: begin
          st_nxt.count[15:8] = bus_req.wdata;
        end
        timer_three_pkg::OFS_RELOAD_LOW: begin
          st_nxt.reload[7:0] = bus_req.wdata;
        end
        timer_three_pkg::OFS_RELOAD_HIGH: begin
          st_nxt.reload[15:8] = bus_req.wdata;
        end
        default: begin
          st_nxt.control = st_nxt.control;
        end
      endcase
    end
    // reads show the live count, not a latched copy
    if (bus_req.rd) begin
      case (bus_req.addr)
        timer_three_pkg::OFS_CONTROL: st_nxt.rd_data = st_r.control;
        timer_three_pkg::OFS_MODE: st_nxt.rd_data = st_r.mode;
        timer_three_pkg::OFS_COUNT_LOW: st_nxt.rd_data = st_r.count[7:0];
        timer_three_pkg::OFS_COUNT_HIGH: st_nxt.rd_data = st_r.count[15:8];
        timer_three_pkg::OFS_RELOAD_LOW: st_nxt.rd_data = st_r.reload[7:0];
        timer_three_pkg::OFS_RELOAD_HIGH: st_nxt.rd_data = st_r.reload[15:8];
        timer_three_pkg::OFS_STATUS: begin
          st_nxt.rd_data = {5'h00, pin_lvl, status};
        end
        timer_three_pkg::OFS_MASK: st_nxt.rd_data = {6'h00, mask};
        default: st_nxt.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '{timer_three_pkg::CONTROL_RST, timer_three_pkg::MODE_RST,
                timer_three_pkg::COUNT_RST, timer_three_pkg::RELOAD_RST,
                8'h00, 1'b0, 1'b0, timer_three_pkg::PIN_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_r = st_r.rd_data;
  assign irq_r = st_r.irq;
  assign baud_tick_r = st_r.tick;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic upd_step;
  logic baud_step;
  logic quiet_flags;
  assign upd_step = running && mode == timer_three_pkg::MODE_UPDOWN
                    && !cnt_wr;
  assign baud_step = running && mode == timer_three_pkg::MODE_BAUD
                     && !cnt_wr;
  assign quiet_flags = !(bus_req.wr
                       && bus_req.addr == timer_three_pkg::OFS_STATUS);

  down_select_a: assert property (
    running && !cnt_wr && !pin_lvl && !at_reload
    && !st_r.control[timer_three_pkg::BIT_CAPTURE_RELOAD_SELECT]
    && st_r.mode[timer_three_pkg::BIT_DOWN_COUNT_ENABLE]
    && !st_r.control[timer_three_pkg::BIT_RECEIVE_CLOCK_SELECT]
    && !st_r.control[timer_three_pkg::BIT_TRANSMIT_CLOCK_SELECT]
    |=> st_r.count == $past(st_r.count) - timer_three_pkg::COUNT_STEP)
    else $error("down count not entered");

  up_step_a: assert property (
    upd_step && pin_lvl && !at_top
    |=> st_r.count == $past(st_r.count) + timer_three_pkg::COUNT_STEP)
    else $error("up count step wrong");

  up_reload_a: assert property (
    upd_step && pin_lvl && at_top |=> st_r.count == $past(st_r.reload))
    else $error("up overflow reload wrong");

  down_reload_a: assert property (
    upd_step && !pin_lvl && at_reload
    |=> st_r.count == timer_three_pkg::COUNT_TOP)
    else $error("down reload not all ones");

  sequence upd_reload_s;
    upd_step && ((pin_lvl && at_top) || (!pin_lvl && at_reload));
  endsequence

  updown_ovf_a: assert property (
    upd_reload_s |=> status[timer_three_pkg::BIT_OVERFLOW_FLAG])
    else $error("reload did not set overflow");

  ext_toggle_a: assert property (
    upd_reload_s |=> status[timer_three_pkg::BIT_EXTERNAL_FLAG]
    != $past(status[timer_three_pkg::BIT_EXTERNAL_FLAG]))
    else $error("reload did not invert external flag");

  updown_noirq_a: assert property (
    mode == timer_three_pkg::MODE_UPDOWN
    && !(status[timer_three_pkg::BIT_OVERFLOW_FLAG]
    && mask[timer_three_pkg::BIT_OVERFLOW_FLAG]) |=> !irq_r)
    else $error("external flag interrupted in up/down mode");

  baud_select_a: assert property (
    running && !cnt_wr && at_top
    && (st_r.control[timer_three_pkg::BIT_RECEIVE_CLOCK_SELECT]
    || st_r.control[timer_three_pkg::BIT_TRANSMIT_CLOCK_SELECT])
    |=> baud_tick_r)
    else $error("clock select did not start baud mode");

  baud_reload_a: assert property (
    baud_step && at_top |=> st_r.count == $past(st_r.reload) && baud_tick_r)
    else $error("baud rollover reload wrong");

  baud_no_ovf_a: assert property (
    baud_step && at_top && !status[timer_three_pkg::BIT_OVERFLOW_FLAG]
    |=> !status[timer_three_pkg::BIT_OVERFLOW_FLAG])
    else $error("baud rollover set overflow");

  sequence fall_seen_s;
    mode == timer_three_pkg::MODE_BAUD && pin_fall
    && st_r.control[timer_three_pkg::BIT_EXTERNAL_ENABLE]
    && mask[timer_three_pkg::BIT_EXTERNAL_FLAG] && !mask_we;
  endsequence

  sequence flag_irq_s;
    status[timer_three_pkg::BIT_EXTERNAL_FLAG] ##1 irq_r;
  endsequence

  ext_fall_a: assert property (
    fall_seen_s ##1 (mode == timer_three_pkg::MODE_BAUD && !mask_we)
    |-> flag_irq_s)
    else $error("falling edge did not raise external flag");

  // sticky until software writes a one over it
  ovf_sticky_a: assert property (
    status[timer_three_pkg::BIT_OVERFLOW_FLAG] && quiet_flags
    |=> status[timer_three_pkg::BIT_OVERFLOW_FLAG])
    else $error("overflow flag dropped without a clear");

  ovf_irq_a: assert property (
    status[timer_three_pkg::BIT_OVERFLOW_FLAG]
    && mask[timer_three_pkg::BIT_OVERFLOW_FLAG] |=> irq_r)
    else $error("unmasked overflow raised no interrupt");

  ext_steady_a: assert property (
    mode == timer_three_pkg::MODE_UPDOWN && quiet_flags
    && !(running && ((pin_lvl && at_top) || (!pin_lvl && at_reload)))
    |=> status[timer_three_pkg::BIT_EXTERNAL_FLAG]
    == $past(status[timer_three_pkg::BIT_EXTERNAL_FLAG]))
    else $error("external flag moved without a reload");

  tick_only_a: assert property (
    !(running && mode == timer_three_pkg::MODE_BAUD && at_top)
    |=> !baud_tick_r)
    else $error("baud tick without rollover");

  ext_gate_a: assert property (
    mode == timer_three_pkg::MODE_BAUD
    && !st_r.control[timer_three_pkg::BIT_EXTERNAL_ENABLE]
    && !status[timer_three_pkg::BIT_EXTERNAL_FLAG]
    |=> !status[timer_three_pkg::BIT_EXTERNAL_FLAG])
    else $error("external flag set with edge detect disabled");

  free_reload_a: assert property (
    running && mode == timer_three_pkg::MODE_FREE && !cnt_wr && at_top
    |=> st_r.count == $past(st_r.reload))
    else $error("free count reload wrong");

  rd_idle_a: assert property (
    !bus_req.rd |=> rd_data_r == 8'h00)
    else $error("read data outside the read slot");

endmodule

/* sim/updown_reload_baud_timer_test.sv */
// self-checking bench for the up/down reload and baud generator timer
`timescale 1ns/100ps
module updown_reload_baud_timer_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  timer_three_pkg::bus_req_s bus_req = '0;
  logic external_trigger_pin = 1'b1;
  logic [timer_three_pkg::DATA_W-1:0] rd_data_r;
  logic irq_r;
  logic baud_tick_r;
  int error_cnt = 0;
  int tests_run = 0;
  int tick_seen = 0;
  int cyc = 0;
  logic [7:0] rv;

  updown_reload_baud_timer dut (
    .clock(clock),
    .rst(rst),
    .bus_req(bus_req),
    .external_trigger_pin(external_trigger_pin),
    .rd_data_r(rd_data_r),
    .irq_r(irq_r),
    .baud_tick_r(baud_tick_r)
  );

  always #4 clock = ~clock;

  // generous ceiling: the whole sequence needs well under 1000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (baud_tick_r === 1'b1) tick_seen <= tick_seen + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clock);
  endtask

  // strobe released one edge later, so back-to-back calls leave a gap
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    bus_req <= '0;
  endtask

  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1;
    d = rd_data_r;
  endtask

  task automatic set_pin(logic v);
    @(posedge clock);
    external_trigger_pin <= v;
    idle(6);
  endtask

  task automatic load(logic [15:0] cnt, logic [15:0] rel);
    wr(4'h2, cnt[7:0]);
    wr(4'h3, cnt[15:8]);
    wr(4'h4, rel[7:0]);
    wr(4'h5, rel[15:8]);
  endtask

  // short run: exactly two count steps between start and stop
  task automatic pulse_run(logic [7:0] ctl);
    wr(4'h0, ctl);
    wr(4'h0, ctl & 8'hfb);
  endtask

  task automatic t_count_up();
    set_pin(1'b1);
    wr(4'h1, 8'h01);
    wr(4'h7, 8'h02);
    load(16'hfffe, 16'h1234);
    pulse_run(8'h04);
    rd(4'h3, rv);
    check("up reload high", rv, 8'h12);
    rd(4'h6, rv);
    check("up status", rv, 8'h07);
    idle(2);
    check("ext flag irq", irq_r, 1'b0);
    wr(4'h7, 8'h03);
    idle(2);
    check("overflow irq", irq_r, 1'b1);
    wr(4'h6, 8'h03);
    idle(2);
    check("irq cleared", irq_r, 1'b0);
    rd(4'h6, rv);
    check("status cleared", rv, 8'h04);
  endtask

  task automatic t_count_down();
    set_pin(1'b0);
    load(16'h1235, 16'h1234);
    pulse_run(8'h04);
    rd(4'h3, rv);
    check("down reload high", rv, 8'hff);
    rd(4'h6, rv);
    check("down status", rv, 8'h03);
    wr(4'h6, 8'h03);
  endtask

  task automatic t_baud();
    logic [7:0] ctl [2] = '{8'h14, 8'h24};
    int t0;
    set_pin(1'b1);
    wr(4'h7, 8'h03);
    foreach (ctl[i]) begin
      load(16'hfffe, 16'habcd);
      t0 = tick_seen;
      pulse_run(ctl[i]);
      idle(2);
      check("baud ticks", tick_seen - t0, 16'h0001);
      rd(4'h3, rv);
      check("baud reload high", rv, 8'hab);
      rd(4'h6, rv);
      check("baud no overflow", rv, 8'h04);
      check("baud no irq", irq_r, 1'b0);
    end
  endtask

  task automatic t_falling_edge();
    wr(4'h0, 8'h10);
    set_pin(1'b0);
    rd(4'h6, rv);
    check("edge ignored", rv, 8'h00);
    set_pin(1'b1);
    wr(4'h0, 8'h18);
    set_pin(1'b0);
    rd(4'h6, rv);
    check("edge flagged", rv, 8'h02);
    check("edge irq", irq_r, 1'b1);
    wr(4'h6, 8'h02);
    idle(2);
    check("edge irq cleared", irq_r, 1'b0);
  endtask

  // capture select set: up/down is off, so a low pin still counts up
  task automatic t_free();
    wr(4'h1, 8'h01);
    load(16'hfffe, 16'h5678);
    pulse_run(8'h05);
    rd(4'h3, rv);
    check("free reload high", rv, 8'h56);
    rd(4'h6, rv);
    check("free status", rv, 8'h01);
  endtask

  // reset with the timer stopped and the pin low: no stray edge flag afterwards
  task automatic t_reset();
    @(posedge clock);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(6);
    check("reset irq again", irq_r, 1'b0);
    rd(4'h3, rv);
    check("reset count high", rv, 8'h00);
    rd(4'h0, rv);
    check("reset control", rv, 8'h00);
    rd(4'h6, rv);
    check("reset status", rv, 8'h00);
  endtask

  initial begin
    idle(6);
    rst <= 1'b0;
    idle(4);
    check("reset irq", irq_r, 1'b0);
    check("reset tick", baud_tick_r, 1'b0);
    rd(4'h9, rv);
    check("unmapped read", rv, 8'h00);
    t_count_up();
    t_count_down();
    t_baud();
    t_falling_edge();
    t_free();
    t_reset();
    end_sim();
  end
endmodule
